// ==== logic/nbh_pkg.sv ====
package nbh_pkg;

   // ----------------------------------------------------------------------
   // Command codes
   // ----------------------------------------------------------------------
   localparam logic [7:0] CMD_READ1      = 8'h00;
   localparam logic [7:0] CMD_READ2      = 8'h30;
   localparam logic [7:0] CMD_RND_OUT1   = 8'h05;
   localparam logic [7:0] CMD_RND_OUT2   = 8'hE0;
   localparam logic [7:0] CMD_CACHE_RND  = 8'h31;
   localparam logic [7:0] CMD_CACHE_END  = 8'h3F;
   localparam logic [7:0] CMD_ID_READ    = 8'h90;
   localparam logic [7:0] CMD_PARAM_PAGE = 8'hEC;
   localparam logic [7:0] CMD_UNIQUE_ID  = 8'hED;
   localparam logic [7:0] CMD_SET_FEAT   = 8'hEF;
   localparam logic [7:0] CMD_GET_FEAT   = 8'hEE;
   localparam logic [7:0] CMD_RESET      = 8'hFF;
   localparam logic [7:0] CMD_PROG1      = 8'h80;
   localparam logic [7:0] CMD_PROG2      = 8'h10;
   localparam logic [7:0] CMD_CACHE_PROG = 8'h15;
   localparam logic [7:0] CMD_PLANE_PROG = 8'h11;
   localparam logic [7:0] CMD_RND_IN     = 8'h85;
   localparam logic [7:0] CMD_ERASE1     = 8'h60;
   localparam logic [7:0] CMD_ERASE2     = 8'hD0;
   localparam logic [7:0] CMD_PLANE_ERS  = 8'hD1;
   localparam logic [7:0] CMD_UNPROT_LO  = 8'h23;
   localparam logic [7:0] CMD_UNPROT_HI  = 8'h24;
   localparam logic [7:0] CMD_PROTECT    = 8'h2A;
   localparam logic [7:0] CMD_SOLID_PROT = 8'h2C;
   localparam logic [7:0] CMD_STATUS     = 8'h70;
   localparam logic [7:0] CMD_STATUS_ENH = 8'h78;
   localparam logic [7:0] CMD_PROT_STAT  = 8'h7A;

   // ----------------------------------------------------------------------
   // Host request kinds
   // ----------------------------------------------------------------------
   localparam logic [1:0] KIND_CMD  = 2'h0;
   localparam logic [1:0] KIND_ADDR = 2'h1;
   localparam logic [1:0] KIND_WDAT = 2'h2;
   localparam logic [1:0] KIND_RDAT = 2'h3;

   // ----------------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------------
   localparam int CLK_PERIOD_NS  = 10;
   localparam int POR_WAIT_US    = 1000;
   localparam int POR_WAIT_CYC   = POR_WAIT_US * 1000 / CLK_PERIOD_NS;
   localparam int T_CYCLE_NS     = 50;   // Strobe period for every bus cycle
   localparam int STROBE_CYC     = (T_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SAMPLE_CYC     = 3;    // Read data captured this late in pulse
   localparam logic [3:0] STROBE_LEN = 4'(STROBE_CYC);
   localparam logic [3:0] SAMPLE_AT  = 4'(SAMPLE_CYC);

   localparam int BLOCK_COUNT    = 4096;
   localparam logic [11:0] LAST_BLOCK = 12'hFFF;
   localparam logic [7:0]  BAD_MARK   = 8'h00;

endpackage

// ==== logic/nbh_cyc_if.sv ====
`timescale 1ns/1ps
interface nbh_cyc_if;
   logic       req;
   logic [1:0] kind;
   logic [7:0] wdata;
   logic       done;
   logic [7:0] rdata;
   modport ctrl (output req, output kind, output wdata, input done, input rdata);
   modport eng  (input req, input kind, input wdata, output done, output rdata);
endinterface

// ==== logic/nbh_cycle_engine.sv ====
`timescale 1ns/1ps
module nbh_cycle_engine (
   input  wire logic   ref_clk_in,      // System clock
   input  wire logic   rst_in,          // Async reset, high
   nbh_cyc_if.eng      cyc,             // One bus cycle request
   output logic        cle_out,         // Command latch select
   output logic        ale_out,         // Address latch select
   output logic        ce_n_out,        // Chip select, low
   output logic        we_n_out,        // Write strobe, low
   output logic        read_strobe_n_out, // Read strobe, low
   output logic [7:0]  io_out,          // Data bus drive value
   output logic        io_oe_out,       // Data bus drive enable
   input  wire logic [7:0] io_sync_in   // Synchronised data bus
);
   logic [3:0] cnt_q;
   logic       busy_q;
   logic [1:0] kind_q;
   logic [7:0] rdata_q;
   logic       done_q;

   assign cyc.done  = done_q;
   assign cyc.rdata = rdata_q;

   // ----------------------------------------------------------------------
   // Strobe sequencing; pins change only from flops
   // ----------------------------------------------------------------------
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         busy_q <= 1'b0;
         cnt_q  <= 4'h0;
         kind_q <= 2'h0;
         done_q <= 1'b0;
      end else begin
         done_q <= 1'b0;
         if (!busy_q && cyc.req) begin
            busy_q <= 1'b1;
            cnt_q  <= 4'h0;
            kind_q <= cyc.kind;
         end else if (busy_q) begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == STROBE_LEN_M1()) begin
               busy_q <= 1'b0;
               done_q <= 1'b1;
            end
         end
      end
   end

   function automatic logic [3:0] STROBE_LEN_M1();
      return nbh_pkg::STROBE_LEN - 4'h1;
   endfunction

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         cle_out <= 1'b0;
         ale_out <= 1'b0;
         ce_n_out <= 1'b1;
         we_n_out <= 1'b1;
         read_strobe_n_out <= 1'b1;
         io_out <= 8'h00;
         io_oe_out <= 1'b0;
      end else if (!busy_q && cyc.req) begin
         // Latch selects set with the falling strobe, two cycles before the rising edge
         ce_n_out <= 1'b0;
         cle_out  <= (cyc.kind == nbh_pkg::KIND_CMD);
         ale_out  <= (cyc.kind == nbh_pkg::KIND_ADDR);
         io_out   <= cyc.wdata;
         io_oe_out <= (cyc.kind != nbh_pkg::KIND_RDAT);
         we_n_out <= (cyc.kind == nbh_pkg::KIND_RDAT);
         read_strobe_n_out <= (cyc.kind != nbh_pkg::KIND_RDAT);
      end else if (busy_q && cnt_q == 4'h1) begin
         we_n_out <= 1'b1;           // Rising edge latches cmd/addr/data
         read_strobe_n_out <= 1'b1;
      end else if (busy_q && cnt_q == STROBE_LEN_M1()) begin
         cle_out  <= 1'b0;
         ale_out  <= 1'b0;
         io_oe_out <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         rdata_q <= 8'h00;
      end else if (busy_q && kind_q == nbh_pkg::KIND_RDAT && cnt_q == nbh_pkg::SAMPLE_AT) begin
         rdata_q <= io_sync_in;
      end
   end
endmodule

// ==== logic/nbh_host.sv ====
`timescale 1ns/1ps
module nbh_host #(
   parameter int POR_WAIT = nbh_pkg::POR_WAIT_CYC
) (
   input  wire logic        ref_clk_in,        // System clock, 100 MHz
   input  wire logic        rst_in,            // Async reset, high
   input  wire logic        op_valid_in,       // User operation request
   output logic             op_ready_out,      // Host can take an operation
   input  wire logic [1:0]  op_kind_in,        // Cycle kind (command/addr/wdata/rdata)
   input  wire logic [7:0]  op_data_in,        // Byte for command/addr/data
   input  wire logic        op_wait_ready_in,  // Wait for ready after this cycle
   output logic             op_done_out,       // Operation complete, pulse
   output logic [7:0]       op_rdata_out,      // Read byte
   output logic             op_reject_out,     // Command refused, pulse
   input  wire logic        scan_start_in,     // Start bad-block scan
   input  wire logic [15:0] spare_col_in,      // Column of first spare byte
   output logic             scan_busy_out,     // Scan running
   output logic             bad_valid_out,     // Bad-block result valid, pulse
   output logic [11:0]      bad_block_out,     // Block number of result
   output logic             bad_flag_out,      // Block is bad
   input  wire logic        wp_enable_in,      // Allow program/erase
   output logic             link_ready_out,    // Power-on wait finished
   output logic             cle_out,           // Command latch select
   output logic             ale_out,           // Address latch select
   output logic             ce_n_out,          // Chip select
   output logic             we_n_out,          // Write strobe
   output logic             read_strobe_n_out, // Read strobe
   output logic             wp_n_out,          // Write protect
   output logic [15:0]      io_out,            // Data bus out
   output logic             io_oe_out,         // Data bus drive enable
   input  wire logic [15:0] io_in,             // Data bus in
   input  wire logic        rb_n_in            // Ready/busy pin
);
   typedef enum logic [6:0] {
      NBH_POR   = 7'h01,
      NBH_IDLE  = 7'h02,
      NBH_CYC   = 7'h04,
      NBH_WAIT  = 7'h08,
      NBH_SCAN  = 7'h10,
      NBH_SWAIT = 7'h20,
      NBH_SRD   = 7'h40
   } nbh_state_t;

   nbh_state_t  state_q;
   nbh_cyc_if   cyc ();
   logic [7:0]  eng_io;
   logic        rb_m_q, rb_q;
   logic [7:0]  io_m_q, io_q;
   logic [31:0] por_q;
   logic        wait_q;
   logic        busy_seen_q;
   logic [11:0] blk_q;
   logic [2:0]  step_q;
   logic        page_q;
   logic        bad_q;
   logic        req_q;
   logic [1:0]  kind_q;
   logic [7:0]  wdat_q;

   // ----------------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------------
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         rb_m_q <= 1'b0;
         rb_q   <= 1'b0;
         io_m_q <= 8'h00;
         io_q   <= 8'h00;
      end else begin
         rb_m_q <= rb_n_in;
         rb_q   <= rb_m_q;
         io_m_q <= io_in[7:0];
         io_q   <= io_m_q;
      end
   end

   nbh_cycle_engine u_eng (
      .ref_clk_in        (ref_clk_in),
      .rst_in            (rst_in),
      .cyc               (cyc.eng),
      .cle_out           (cle_out),
      .ale_out           (ale_out),
      .ce_n_out          (ce_n_out),
      .we_n_out          (we_n_out),
      .read_strobe_n_out (read_strobe_n_out),
      .io_out            (eng_io),
      .io_oe_out         (io_oe_out),
      .io_sync_in        (io_q)
   );

   assign io_out       = {8'h00, eng_io};
   assign cyc.req      = req_q;
   assign cyc.kind     = kind_q;
   assign cyc.wdata    = wdat_q;
   assign op_ready_out = (state_q == NBH_IDLE) && !req_q;
   assign scan_busy_out = (state_q == NBH_SCAN) || (state_q == NBH_SWAIT)
                          || (state_q == NBH_SRD);

   function automatic logic cmd_known(input logic [7:0] c);
      case (c)
         nbh_pkg::CMD_READ1, nbh_pkg::CMD_READ2, nbh_pkg::CMD_RND_OUT1,
         nbh_pkg::CMD_RND_OUT2, nbh_pkg::CMD_CACHE_RND, nbh_pkg::CMD_CACHE_END,
         nbh_pkg::CMD_PROG1, nbh_pkg::CMD_PROG2, nbh_pkg::CMD_CACHE_PROG,
         nbh_pkg::CMD_RND_IN, nbh_pkg::CMD_ERASE1, nbh_pkg::CMD_ERASE2,
         nbh_pkg::CMD_PLANE_PROG, nbh_pkg::CMD_PLANE_ERS,
         nbh_pkg::CMD_ID_READ, nbh_pkg::CMD_PARAM_PAGE, nbh_pkg::CMD_UNIQUE_ID,
         nbh_pkg::CMD_SET_FEAT, nbh_pkg::CMD_GET_FEAT,
         nbh_pkg::CMD_UNPROT_LO, nbh_pkg::CMD_UNPROT_HI, nbh_pkg::CMD_PROTECT,
         nbh_pkg::CMD_SOLID_PROT, nbh_pkg::CMD_PROT_STAT,
         nbh_pkg::CMD_RESET, nbh_pkg::CMD_STATUS, nbh_pkg::CMD_STATUS_ENH:
            cmd_known = 1'b1;
         default: cmd_known = 1'b0;
      endcase
   endfunction

   // Scan byte sequence per page: 00h, col lo, col hi, row0, row1, row2, 30h
   function automatic logic [9:0] scan_step(input logic [2:0] s, input logic [15:0] col,
                                           input logic [11:0] blk, input logic pg);
      logic [17:0] row;
      row = {blk, 5'h00, pg};
      case (s)
         3'h0: scan_step = {nbh_pkg::KIND_CMD, nbh_pkg::CMD_READ1};
         3'h1: scan_step = {nbh_pkg::KIND_ADDR, col[7:0]};
         3'h2: scan_step = {nbh_pkg::KIND_ADDR, col[15:8]};
         3'h3: scan_step = {nbh_pkg::KIND_ADDR, row[7:0]};
         3'h4: scan_step = {nbh_pkg::KIND_ADDR, row[15:8]};
         3'h5: scan_step = {nbh_pkg::KIND_ADDR, 6'h00, row[17:16]};
         3'h6: scan_step = {nbh_pkg::KIND_CMD, nbh_pkg::CMD_READ2};
         default: scan_step = {nbh_pkg::KIND_RDAT, 8'h00};
      endcase
   endfunction

   // ----------------------------------------------------------------------
   // Write protect: low until power-on done and user allows writes
   // ----------------------------------------------------------------------
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         wp_n_out <= 1'b0;
      end else begin
         // Not held during busy; dropping wp_enable_in lowers it on the next clock and aborts a running program
         wp_n_out <= (state_q != NBH_POR) && wp_enable_in;
      end
   end

   // ----------------------------------------------------------------------
   // Power-on wait
   // ----------------------------------------------------------------------
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         por_q <= 32'h0;
         link_ready_out <= 1'b0;
      end else if (state_q == NBH_POR) begin
         por_q <= por_q + 32'h1;
      end else begin
         link_ready_out <= 1'b1;
      end
   end

   // ----------------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------------
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_q <= NBH_POR;
         req_q <= 1'b0;
         kind_q <= 2'h0;
         wdat_q <= 8'h00;
         wait_q <= 1'b0;
         busy_seen_q <= 1'b0;
         op_done_out <= 1'b0;
         op_reject_out <= 1'b0;
         op_rdata_out <= 8'h00;
         blk_q <= 12'h000;
         step_q <= 3'h0;
         page_q <= 1'b0;
         bad_q <= 1'b0;
         bad_valid_out <= 1'b0;
         bad_block_out <= 12'h000;
         bad_flag_out <= 1'b0;
      end else begin
         op_done_out <= 1'b0;
         op_reject_out <= 1'b0;
         bad_valid_out <= 1'b0;
         req_q <= 1'b0;
         case (state_q)
            NBH_POR: begin
               // Ready only counts once the counter shows the pin really settled
               if (por_q >= 32'(POR_WAIT) || (rb_q && por_q > 32'h10)) begin
                  state_q <= NBH_IDLE;
               end
            end
            NBH_IDLE: begin
               if (scan_start_in) begin
                  blk_q <= 12'h000;
                  page_q <= 1'b0;
                  step_q <= 3'h0;
                  bad_q <= 1'b0;
                  state_q <= NBH_SCAN;
               end else if (op_valid_in) begin
                  if (op_kind_in == nbh_pkg::KIND_CMD && !cmd_known(op_data_in)) begin
                     op_reject_out <= 1'b1;
                  end else begin
                     req_q <= 1'b1;
                     kind_q <= op_kind_in;
                     wdat_q <= op_data_in;
                     wait_q <= op_wait_ready_in;
                     state_q <= NBH_CYC;
                  end
               end
            end
            NBH_CYC: begin
               if (cyc.done) begin
                  op_rdata_out <= cyc.rdata;
                  busy_seen_q <= 1'b0;
                  if (wait_q) begin
                     state_q <= NBH_WAIT;
                  end else begin
                     op_done_out <= 1'b1;
                     state_q <= NBH_IDLE;
                  end
               end
            end
            NBH_WAIT: begin
               // Busy may assert late; wait to see it drop before trusting high
               if (!rb_q) begin
                  busy_seen_q <= 1'b1;
               end else if (busy_seen_q) begin
                  op_done_out <= 1'b1;
                  state_q <= NBH_IDLE;
               end
            end
            NBH_SCAN: begin
               if (!req_q) begin
                  req_q <= 1'b1;
                  {kind_q, wdat_q} <= scan_step(step_q, spare_col_in, blk_q, page_q);
                  state_q <= NBH_SWAIT;
               end
            end
            NBH_SWAIT: begin
               if (cyc.done) begin
                  if (step_q == 3'h6) begin
                     busy_seen_q <= 1'b0;
                     state_q <= NBH_SRD;
                  end else if (step_q == 3'h7) begin
                     if (cyc.rdata == nbh_pkg::BAD_MARK) begin
                        bad_q <= 1'b1;
                     end
                     step_q <= 3'h0;
                     if (page_q) begin
                        bad_valid_out <= 1'b1;
                        bad_block_out <= blk_q;
                        bad_flag_out <= bad_q || (cyc.rdata == nbh_pkg::BAD_MARK);
                        bad_q <= 1'b0;
                        page_q <= 1'b0;
                        blk_q <= blk_q + 12'h001;
                        state_q <= (blk_q == nbh_pkg::LAST_BLOCK) ? NBH_IDLE : NBH_SCAN;
                     end else begin
                        page_q <= 1'b1;
                        state_q <= NBH_SCAN;
                     end
                  end else begin
                     step_q <= step_q + 3'h1;
                     state_q <= NBH_SCAN;
                  end
               end
            end
            NBH_SRD: begin
               if (!rb_q) begin
                  busy_seen_q <= 1'b1;
               end else if (busy_seen_q) begin
                  step_q <= 3'h7;
                  state_q <= NBH_SCAN;
               end
            end
            default: state_q <= NBH_IDLE;
         endcase
      end
   end
endmodule

// ==== tb/nbh_host_sva.sv ====
`timescale 1ns/1ps
module nbh_host_sva (
   input wire logic        ref_clk_in,        // Clock
   input wire logic        rst_in,            // Reset
   input wire logic        op_valid_in,       // Request
   input wire logic        op_ready_out,      // Idle
   input wire logic [1:0]  op_kind_in,        // Kind
   input wire logic [7:0]  op_data_in,        // Byte
   input wire logic        op_done_out,       // Done
   input wire logic        cle_out,           // Command latch
   input wire logic        ale_out,           // Address latch
   input wire logic        ce_n_out,          // Select
   input wire logic        we_n_out,          // Write strobe
   input wire logic        read_strobe_n_out, // Read strobe
   input wire logic        wp_n_out,          // Protect
   input wire logic [15:0] io_out,            // Bus
   input wire logic        io_oe_out,         // Bus enable
   input wire logic        link_ready_out     // Power-on over
);
   // ----------------------------------------------------------------
   // Pin protocol
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);
   sequence s_req(k);
      op_valid_in && op_ready_out && op_kind_in == k;
   endsequence
   sequence s_pins(c, a);
      !ce_n_out && !we_n_out && read_strobe_n_out && cle_out == c && ale_out == a;
   endsequence
   // Unknown codes are refused without pins, so only a known code is traced
   property p_cmd;
      s_req(nbh_pkg::KIND_CMD) ##0 op_data_in == nbh_pkg::CMD_STATUS
         |-> ##[1:6] s_pins(1'b1, 1'b0);
   endproperty
   property p_addr;
      s_req(nbh_pkg::KIND_ADDR) |-> ##[1:6] s_pins(1'b0, 1'b1);
   endproperty
   property p_done;
      op_done_out |=> !op_done_out;
   endproperty
   property p_upper;
      cle_out && !we_n_out |-> io_oe_out && io_out[15:8] == 8'h00;
   endproperty
   property p_por_ce;
      !link_ready_out |-> ce_n_out && we_n_out;
   endproperty
   property p_por_wp;
      !link_ready_out |-> !wp_n_out;
   endproperty
   property p_excl;
      !we_n_out |-> read_strobe_n_out && !(cle_out && ale_out);
   endproperty
   property p_read;
      !read_strobe_n_out |-> !cle_out && !ale_out && !io_oe_out && we_n_out;
   endproperty
   a_cmd: assert property (p_cmd) else $error("command cycle pins wrong");
   a_addr: assert property (p_addr) else $error("address cycle pins wrong");
   a_done: assert property (p_done) else $error("done longer than a cycle");
   a_upper: assert property (p_upper) else $error("upper bus lines not zero");
   a_por_ce: assert property (p_por_ce) else $error("bus used before power-on end");
   a_por_wp: assert property (p_por_wp) else $error("protect high in power-up");
   a_excl: assert property (p_excl) else $error("write strobe with bad latches");
   a_read: assert property (p_read) else $error("read strobe with bad pins");
endmodule
bind nbh_host nbh_host_sva nbh_host_sva_inst (.ref_clk_in, .rst_in, .op_valid_in, .op_ready_out,
   .op_kind_in, .op_data_in, .op_done_out, .cle_out, .ale_out, .ce_n_out, .we_n_out,
   .read_strobe_n_out, .wp_n_out, .io_out, .io_oe_out, .link_ready_out);

// ==== tb/nbh_flash_model.sv ====
`timescale 1ns/1ps
module nbh_flash_model #(
   parameter realtime     POR_NS    = 500.0,
   parameter realtime     BUSY_NS   = 1000.0,
   parameter logic [15:0] SPARE_COL = 16'h0800,
   parameter logic [11:0] BAD_BLK   = 12'h001
) (
   input  wire logic        cle_in,           // Command latch
   input  wire logic        ale_in,           // Address latch
   input  wire logic        ce_n_in,          // Select
   input  wire logic        we_n_in,          // Write strobe
   input  wire logic        read_strobe_n_in, // Read strobe
   input  wire logic        wp_n_in,          // Protect
   input  wire logic [15:0] io_in,            // Resolved bus
   output logic [15:0]      io_out,           // Read drive
   output logic             rb_n_out          // Ready/busy
);
   // ----------------------------------------------------------------
   // Device behaviour
   // ----------------------------------------------------------------
   realtime    t_end  = POR_NS;
   logic       busy_q = 1'b1;
   logic       stat_q = 1'b0;
   logic       pe_q   = 1'b0;
   logic [7:0] a_q [5];
   int         n_a    = 0;
   logic [7:0] dout;
   logic [7:0] last_q = 8'h00;
   wire  [7:0] cmd    = io_in[7:0];
   wire [17:0] row    = {a_q[4][1:0], a_q[3], a_q[2]};
   // Polled off the clock grid so the host never sees a same-step race
   always #2 busy_q = ($realtime < t_end);
   assign rb_n_out = !busy_q;
   always @(negedge wp_n_in) if (pe_q) t_end = $realtime;
   always @(posedge we_n_in) begin
      if (!ce_n_in && read_strobe_n_in && $realtime >= POR_NS) begin
         if (cle_in && !ale_in &&
             (!busy_q || cmd inside {8'hFF, 8'h70, 8'h78})) begin
            n_a = 0;
            stat_q = cmd inside {8'h70, 8'h78};
            case (cmd)
               8'h30, 8'h31, 8'h3F, 8'hFF, 8'hD1, 8'h11: t_end = $realtime + BUSY_NS;
               8'h10, 8'h15, 8'hD0: if (wp_n_in) begin
                  pe_q = 1'b1;
                  t_end = $realtime + BUSY_NS;
               end
               default: ;
            endcase
         end else if (ale_in && !cle_in && n_a < 5) begin
            a_q[n_a] = cmd;
            n_a++;
         end
      end
   end
   always_comb begin
      if (stat_q) dout = {wp_n_in, !busy_q, 6'h00};
      else if ({a_q[1], a_q[0]} == SPARE_COL && row[17:6] == BAD_BLK && row[5:0] < 6'h02)
         dout = 8'h00;
      else dout = 8'hFF;
   end
   // No pull-ups on the data lines, so a released bus shows changed values
   assign io_out = (!ce_n_in && !read_strobe_n_in) ? {8'h00, dout} : ~{8'h00, last_q};
   always @(posedge read_strobe_n_in) last_q = dout;
endmodule

// ==== tb/nbh_host_test.sv ====
`timescale 1ns/1ps
module nbh_host_test;
   typedef struct packed {
      logic [1:0] k;
      logic       w;
      logic       rj;
      logic [7:0] d;
      logic [7:0] e;
   } nbh_row_t;
   logic        ref_clk_in = 1'b0;
   logic        rst_in = 1'b1;
   logic        op_valid_in = 1'b0;
   logic [1:0]  op_kind_in = 2'h0;
   logic [7:0]  op_data_in = 8'h00;
   logic        op_wait_ready_in = 1'b0;
   logic        scan_start_in = 1'b0;
   logic        wp_enable_in = 1'b1;
   wire  [15:0] h_io, m_io, bus;
   wire         rb_n, op_ready_out, op_done_out, op_reject_out, scan_busy_out, bad_valid_out;
   wire         bad_flag_out, link_ready_out, cle_out, ale_out, ce_n_out, we_n_out, wp_n_out;
   wire         read_strobe_n_out, io_oe_out;
   wire  [7:0]  op_rdata_out;
   wire  [11:0] bad_block_out;
   int          n_errors = 0, n_tests = 0, cyc = 0;
   logic [7:0]  rd;
   logic        rj;
   // Rows: kind, wait, refused, byte, expected read byte
   nbh_row_t    rows [19] = '{20'h2FF00, 20'h07000, 20'hC00C0, 20'h00000, 20'h40000, 20'h40800,
      20'h44000, 20'h40000, 20'h40000, 20'h23000, 20'hC0000, 20'h14200, 20'h08000, 20'h40000,
      20'h85A00, 20'h21000, 20'h06000, 20'h40000, 20'h2D000};
   logic [7:0]  codes [27] = '{8'h00, 8'h30, 8'h05, 8'hE0, 8'h31, 8'h3F, 8'h90, 8'hEC, 8'hED,
      8'hEF, 8'hEE, 8'hFF, 8'h80, 8'h10, 8'h15, 8'h85, 8'h60, 8'hD0, 8'h23, 8'h24, 8'h2A, 8'h2C,
      8'h70, 8'h78, 8'h7A, 8'h11, 8'hD1};
   nbh_host #(.POR_WAIT(200)) nbh_host_inst (.ref_clk_in, .rst_in, .op_valid_in, .op_ready_out,
      .op_kind_in, .op_data_in, .op_wait_ready_in, .op_done_out, .op_rdata_out, .op_reject_out,
      .scan_start_in, .spare_col_in(16'h0800), .scan_busy_out, .bad_valid_out, .bad_block_out,
      .bad_flag_out, .wp_enable_in, .link_ready_out, .cle_out, .ale_out, .ce_n_out, .we_n_out,
      .read_strobe_n_out, .wp_n_out, .io_out(h_io), .io_oe_out, .io_in(bus), .rb_n_in(rb_n));
   nbh_flash_model nbh_flash_model_inst (.cle_in(cle_out), .ale_in(ale_out), .ce_n_in(ce_n_out),
      .we_n_in(we_n_out), .read_strobe_n_in(read_strobe_n_out), .wp_n_in(wp_n_out), .io_in(bus),
      .io_out(m_io), .rb_n_out(rb_n));
   assign bus = io_oe_out ? h_io : m_io;
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   initial forever #5 ref_clk_in = ~ref_clk_in;
   task automatic end_sim();
      $display("errors %0d tests %0d", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   always @(posedge ref_clk_in) begin
      cyc++;
      if (cyc == 10000) begin
         n_errors++;
         end_sim();
      end
   end
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      n_tests++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic op(input logic [1:0] k, input logic [7:0] d, input logic w);
      do @(posedge ref_clk_in) #1; while (op_ready_out !== 1'b1);
      {op_kind_in, op_data_in, op_wait_ready_in, op_valid_in} = {k, d, w, 1'b1};
      @(posedge ref_clk_in) #1;
      op_valid_in = 1'b0;
      while (op_done_out !== 1'b1 && op_reject_out !== 1'b1) @(posedge ref_clk_in) #1;
      rd = op_rdata_out;
      rj = op_reject_out;
   endtask
   task automatic stat(input logic [7:0] e);
      op(2'h0, 8'h70, 1'b0);
      op(2'h3, 8'h00, 1'b0);
      chk(rd, e);
   endtask
   task automatic prog();
      op(2'h0, 8'h80, 1'b0);
      op(2'h0, 8'h10, 1'b0);
   endtask
   // ----------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (3) @(posedge ref_clk_in);
      chk({ce_n_out, wp_n_out}, 2'h2);
      #1 rst_in = 1'b0;
      while (link_ready_out !== 1'b1) @(posedge ref_clk_in) #1;
      $display("reset test done");
      foreach (rows[i]) begin
         op(rows[i].k, rows[i].d, rows[i].w);
         chk(rj, rows[i].rj);
         if (rows[i].k == 2'h3) chk(rd, rows[i].e);
      end
      $display("table test done");
      foreach (codes[i]) begin
         op(2'h0, codes[i], 1'b0);
         chk(rj, 1'b0);
      end
      while (rb_n !== 1'b1) @(posedge ref_clk_in) #1;
      $display("code test done");
      prog();
      stat(8'h80);
      wp_enable_in = 1'b0;
      stat(8'h40);
      prog();
      stat(8'h40);
      wp_enable_in = 1'b1;
      $display("protect test done");
      scan_start_in = 1'b1;
      while (scan_busy_out !== 1'b1) @(posedge ref_clk_in) #1;
      scan_start_in = 1'b0;
      for (int b = 0; b < 3; b++) begin
         do @(posedge ref_clk_in) #1; while (bad_valid_out !== 1'b1);
         chk({bad_block_out, 3'h0, bad_flag_out}, {12'(b), 3'h0, b == 1});
      end
      // Reset lands mid-scan on purpose
      rst_in = 1'b1;
      @(posedge ref_clk_in) #1;
      chk({ce_n_out, wp_n_out, scan_busy_out}, 3'h4);
      rst_in = 1'b0;
      while (link_ready_out !== 1'b1) @(posedge ref_clk_in) #1;
      stat(8'hC0);
      $display("scan and reset test done");
      end_sim();
   end
endmodule
